//--- rtl/tsa_top.sv
/*
 * Temperature sensor register block: two-wire slave, pointer, configuration,
 * limits, result register and conversion scheduling.
 * Assumes an external converter that takes adcStart and answers with adcDone
 * and a 12-bit code, on the same clock; the bus pins come from outside.
 */
`timescale 1ns/1ps
`include "tsa_consts.svh"

module tsa_top #(
	parameter int unsigned CONV_CYCLES = `TSA_CONV_PERIOD_MS * (`TSA_CLK_HZ / 1000)
) (
	input  wire logic        ref_clk,       // Block clock, 10 MHz
	input  wire logic        nrst,          // Async reset, active low
	input  wire logic        sclPin,        // Bus clock pin level
	input  wire logic        sdaIn,         // Bus data pin level
	output logic             sdaOut,        // Bus data drive value
	output logic             sdaOe,         // Bus data pull-low enable
	output logic             tempAlertOut,  // Alert pin drive value
	output logic             tempAlertOe,   // Alert pin pull-low enable
	output logic             adcStart,      // Conversion start pulse
	output logic             sensorPowered, // Analog front end powered
	input  wire logic        adcDone,       // Conversion done pulse
	input  wire logic [11:0] adcCode        // Converted signed code
);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	// ------------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------------
	logic [1:0] pinRaw;
	logic [1:0] pinClean;
	logic       sclNow;
	logic       sdaNow;
	logic       sclPrevReg;
	logic       sdaPrevReg;
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;

	assign pinRaw = {sclPin, sdaIn};

	tsa_pin_sync u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.pinIn   (pinRaw),
		.pinOut  (pinClean)
	);

	assign sclNow = pinClean[1];
	assign sdaNow = pinClean[0];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sclPrevReg <= 1'b1;
			sdaPrevReg <= 1'b1;
		end else begin
			sclPrevReg <= sclNow;
			sdaPrevReg <= sdaNow;
		end
	end

	assign sclRise = sclNow && !sclPrevReg;
	assign sclFall = !sclNow && sclPrevReg;
	assign startCond = sclNow && sclPrevReg && sdaPrevReg && !sdaNow;
	assign stopCond = sclNow && sclPrevReg && !sdaPrevReg && sdaNow;

	// ------------------------------------------------------------------
	// Serial slave
	// ------------------------------------------------------------------
	tsa_pkg::tsa_ser_state_t stateReg;
	logic [3:0]  bitCntReg;
	logic [7:0]  rxShiftReg;
	logic [7:0]  txShiftReg;
	logic        readReg;
	logic        ackedReg;
	logic        firstByteReg;
	logic        lowByteReg;
	logic [7:0]  holdHighReg;
	logic [15:0] readWordReg;
	logic        wrByteStrobe;
	logic        dataByteStrobe;
	logic        loadTx;
	logic [7:0]  readByte;
	logic [15:0] selWord;
	logic        selWide;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stateReg <= tsa_pkg::SER_IDLE;
			bitCntReg <= 4'h0;
			rxShiftReg <= 8'h00;
			readReg <= 1'b0;
			ackedReg <= 1'b0;
		end else if (startCond) begin
			stateReg <= tsa_pkg::SER_ADDR;
			bitCntReg <= 4'h0;
		end else if (stopCond) begin
			stateReg <= tsa_pkg::SER_IDLE;
		end else begin
			case (stateReg)
				tsa_pkg::SER_ADDR, tsa_pkg::SER_WRITE: begin
					if (sclRise && bitCntReg != 4'h8) begin
						rxShiftReg <= {rxShiftReg[6:0], sdaNow};
						bitCntReg <= bitCntReg + 4'h1;
					end
					if (sclFall && bitCntReg == 4'h8) begin
						if (stateReg == tsa_pkg::SER_WRITE) begin
							stateReg <= tsa_pkg::SER_ACK_WRITE;
						end else if (rxShiftReg[7:1] == `TSA_DEV_ADDR) begin
							stateReg <= tsa_pkg::SER_ACK_ADDR;
							readReg <= rxShiftReg[0];
						end else begin
							stateReg <= tsa_pkg::SER_IDLE;
						end
					end
				end
				tsa_pkg::SER_ACK_ADDR: begin
					if (sclFall) begin
						bitCntReg <= 4'h0;
						stateReg <= readReg ? tsa_pkg::SER_READ : tsa_pkg::SER_WRITE;
					end
				end
				tsa_pkg::SER_ACK_WRITE: begin
					if (sclFall) begin
						bitCntReg <= 4'h0;
						stateReg <= tsa_pkg::SER_WRITE;
					end
				end
				tsa_pkg::SER_READ: begin
					if (sclFall) begin
						if (bitCntReg == 4'h7) begin
							bitCntReg <= 4'h0;
							stateReg <= tsa_pkg::SER_READ_ACK;
						end else begin
							bitCntReg <= bitCntReg + 4'h1;
						end
					end
				end
				tsa_pkg::SER_READ_ACK: begin
					if (sclRise) begin
						ackedReg <= !sdaNow;
					end
					if (sclFall) begin
						stateReg <= ackedReg ? tsa_pkg::SER_READ : tsa_pkg::SER_IDLE;
					end
				end
				default: begin
					stateReg <= tsa_pkg::SER_IDLE;
				end
			endcase
		end
	end

	assign wrByteStrobe = sclFall && stateReg == tsa_pkg::SER_WRITE && bitCntReg == 4'h8;
	assign dataByteStrobe = wrByteStrobe && !firstByteReg;
	assign loadTx = sclFall && ((stateReg == tsa_pkg::SER_ACK_ADDR && readReg)
		|| (stateReg == tsa_pkg::SER_READ_ACK && ackedReg));

	// ------------------------------------------------------------------
	// Register selector and byte order
	// ------------------------------------------------------------------
	logic [7:0]  selReg;
	logic [7:0]  cfgReg;
	logic [15:0] hystReg;
	logic [15:0] limitReg;
	logic [15:0] tempResultReg;
	logic        oneShotReq;

	// The first byte of every write transfer lands in the selector.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			selReg <= `TSA_SEL_RESET;
		end else if (wrByteStrobe && firstByteReg) begin
			selReg <= rxShiftReg;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			firstByteReg <= 1'b1;
		end else if (startCond) begin
			firstByteReg <= 1'b1;
		end else if (wrByteStrobe) begin
			firstByteReg <= 1'b0;
		end
	end

	// Only the three low selector bits decode; codes five to seven hit nothing.
	always_comb begin
		selWord = 16'h0000;
		selWide = 1'b0;
		if (selReg[2:0] == `TSA_SEL_TEMP) begin
			selWord = tempResultReg;
			selWide = 1'b1;
		end else if (selReg[2:0] == `TSA_SEL_HYST) begin
			selWord = hystReg;
			selWide = 1'b1;
		end else if (selReg[2:0] == `TSA_SEL_LIMIT) begin
			selWord = limitReg;
			selWide = 1'b1;
		end else if (selReg[2:0] == `TSA_SEL_CFG) begin
			selWord = {cfgReg, cfgReg};
		end
	end

	// Wide registers give the high byte first, then the low byte.
	assign readByte = !selWide ? selWord[15:8]
		: (lowByteReg ? readWordReg[7:0] : selWord[15:8]);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lowByteReg <= 1'b0;
		end else if (startCond) begin
			lowByteReg <= 1'b0;
		end else if (loadTx && selWide) begin
			lowByteReg <= !lowByteReg;
		end else if (dataByteStrobe && (selReg[2:0] == `TSA_SEL_HYST
			|| selReg[2:0] == `TSA_SEL_LIMIT)) begin
			lowByteReg <= !lowByteReg;
		end
	end

	// The whole word is caught with its high byte so both halves match.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			readWordReg <= 16'h0000;
		end else if (loadTx && !lowByteReg) begin
			readWordReg <= selWord;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txShiftReg <= 8'h00;
		end else if (loadTx) begin
			txShiftReg <= readByte;
		end else if (sclFall && stateReg == tsa_pkg::SER_READ) begin
			txShiftReg <= {txShiftReg[6:0], 1'b0};
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe = stateReg == tsa_pkg::SER_ACK_ADDR || stateReg == tsa_pkg::SER_ACK_WRITE
		|| (stateReg == tsa_pkg::SER_READ && !txShiftReg[7]);

	// ------------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cfgReg <= `TSA_CFG_RESET;
		end else if (dataByteStrobe && selReg[2:0] == `TSA_SEL_CFG) begin
			cfgReg <= rxShiftReg;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			holdHighReg <= 8'h00;
		end else if (dataByteStrobe && !lowByteReg) begin
			holdHighReg <= rxShiftReg;
		end
	end

	// A limit changes only when its low byte arrives; the pad stays zero.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hystReg <= `TSA_HYST_RESET;
			limitReg <= `TSA_LIMIT_RESET;
		end else if (dataByteStrobe && lowByteReg) begin
			if (selReg[2:0] == `TSA_SEL_HYST) begin
				hystReg <= {holdHighReg, rxShiftReg[7:4], `TSA_LSB_PAD};
			end else if (selReg[2:0] == `TSA_SEL_LIMIT) begin
				limitReg <= {holdHighReg, rxShiftReg[7:4], `TSA_LSB_PAD};
			end
		end
	end

	// The one-shot byte itself is thrown away; only the write matters.
	assign oneShotReq = dataByteStrobe && selReg[2:0] == `TSA_SEL_ONESHOT;

	// ------------------------------------------------------------------
	// Conversion scheduling
	// ------------------------------------------------------------------
	logic          poweredDown;
	logic          convBusyReg;
	logic          adcStartReg;
	logic          resultValidReg;
	logic          periodHit;
	logic          startConv;
	logic [CW-1:0] periodCntReg;

	assign poweredDown = cfgReg[`TSA_CFG_SHUTDOWN] || cfgReg[`TSA_CFG_ONESHOT];
	assign periodHit = periodCntReg == CW'(CONV_CYCLES - 1);
	assign startConv = !convBusyReg
		&& ((!poweredDown && periodHit) || (poweredDown && oneShotReq));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			periodCntReg <= '0;
		end else if (poweredDown || periodHit) begin
			periodCntReg <= '0;
		end else begin
			periodCntReg <= periodCntReg + CW'(1);
		end
	end

	// A conversion under way always completes, even if shutdown comes.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			convBusyReg <= 1'b0;
			adcStartReg <= 1'b0;
		end else begin
			adcStartReg <= startConv;
			if (startConv) begin
				convBusyReg <= 1'b1;
			end else if (adcDone) begin
				convBusyReg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tempResultReg <= `TSA_TEMP_RESET;
			resultValidReg <= 1'b0;
		end else begin
			resultValidReg <= adcDone && convBusyReg;
			if (adcDone && convBusyReg) begin
				tempResultReg <= {adcCode, `TSA_LSB_PAD};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sensorPowered <= 1'b0;
		end else begin
			sensorPowered <= !poweredDown || startConv || convBusyReg;
		end
	end

	assign adcStart = adcStartReg;

	// ------------------------------------------------------------------
	// Alert output
	// ------------------------------------------------------------------
	tsa_alert u_alert (
		.ref_clk      (ref_clk),
		.nrst         (nrst),
		.resultValid  (resultValidReg),
		.result       (tempResultReg),
		.overLimit    (limitReg),
		.hystLimit    (hystReg),
		.faultSel     (cfgReg[`TSA_CFG_FQ_HI:`TSA_CFG_FQ_LO]),
		.intMode      (cfgReg[`TSA_CFG_INTMODE]),
		.polarityHigh (cfgReg[`TSA_CFG_POLARITY]),
		.regRead      (loadTx),
		.alertActive  (),
		.alertPullLow (tempAlertOe)
	);

	assign tempAlertOut = 1'b0;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence oneShotKick;
		oneShotReq && poweredDown && !convBusyReg;
	endsequence

	sequence startThenBusy;
		adcStartReg && convBusyReg;
	endsequence

	oneshot_start_a: assert property (oneShotKick |=> startThenBusy)
		else $error("one-shot write did not start conversion");
	powered_idle_a: assert property (poweredDown && !oneShotReq |=> !adcStartReg)
		else $error("conversion started while powered down");
	result_pad_a: assert property (adcDone && convBusyReg
		|=> tempResultReg == {$past(adcCode), `TSA_LSB_PAD})
		else $error("stored result does not match code");
	result_hold_a: assert property (!(adcDone && convBusyReg) |=> $stable(tempResultReg))
		else $error("result changed without conversion");
	period_start_a: assert property (!poweredDown && periodHit && !convBusyReg
		|=> adcStartReg)
		else $error("periodic conversion missing");
	limit_pad_a: assert property (limitReg[3:0] == `TSA_LSB_PAD
		&& hystReg[3:0] == `TSA_LSB_PAD)
		else $error("limit low bits not zero");
endmodule

//--- inc/tsa_consts.svh
/*
 * Constants of the temperature sensor register block: selector codes, reset
 * values, configuration bit positions, fault queue depths and timing.
 * Assumes it is included by bare name wherever these values are needed.
 */
// Function
// - Words hold left-aligned 12-bit signed values
// - One count equals one sixteenth degree
// - High byte first, then low byte
// - One-shot bit powers the sensor down
// - One-shot write runs exactly one conversion
// - Fault queue depth one, two, four, six
// - Alert only after consecutive faults
// - Selector low three bits choose register
// - Selector clears to temperature at reset
// - Temperature read-only, one-shot write-only, others read and write
// - Documented power-on register values
// - Normal mode converts periodically
// - Bit two sets alert polarity
// - Bit one selects comparator or interrupt
// - Shutdown bit stops periodic conversions
// - Fault when temperature reaches limit
// - Comparator clears below hysteresis
// - Interrupt clears after read and below hysteresis
// - Reads return stored value during conversion
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

`define TSA_SEL_TEMP       3'h0
`define TSA_SEL_CFG        3'h1
`define TSA_SEL_HYST       3'h2
`define TSA_SEL_LIMIT      3'h3
`define TSA_SEL_ONESHOT    3'h4

`define TSA_SEL_RESET      8'h00
`define TSA_TEMP_RESET     16'h0000
`define TSA_CFG_RESET      8'h00
`define TSA_HYST_RESET     16'h4B00
`define TSA_LIMIT_RESET    16'h5000

`define TSA_CFG_SHUTDOWN   0
`define TSA_CFG_INTMODE    1
`define TSA_CFG_POLARITY   2
`define TSA_CFG_FQ_LO      3
`define TSA_CFG_FQ_HI      4
`define TSA_CFG_ONESHOT    5

`define TSA_FQ_DEPTH0      3'h1
`define TSA_FQ_DEPTH1      3'h2
`define TSA_FQ_DEPTH2      3'h4
`define TSA_FQ_DEPTH3      3'h6

`define TSA_LSB_PAD        4'h0
`define TSA_DEV_ADDR       7'h48
`define TSA_SYNC_W         2
`define TSA_CLK_HZ         10000000
`define TSA_CONV_PERIOD_MS 60

`endif

//--- inc/tsa_pkg.sv
/*
 * Types of the temperature sensor register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tsa_pkg;
	typedef enum logic [2:0] {
		SER_IDLE,
		SER_ADDR,
		SER_ACK_ADDR,
		SER_WRITE,
		SER_ACK_WRITE,
		SER_READ,
		SER_READ_ACK
	} tsa_ser_state_t;
endpackage

//--- rtl/tsa_pin_sync.sv
/*
 * Three-stage pin synchroniser with an agreement filter on the bus pins.
 * Assumes idle pins are high, as on a pulled-up two-wire bus.
 */
`timescale 1ns/1ps
`include "tsa_consts.svh"

module tsa_pin_sync (
	input  wire logic                   ref_clk,  // Block clock
	input  wire logic                   nrst,     // Async reset, active low
	input  wire logic [`TSA_SYNC_W-1:0] pinIn,    // Raw pin levels
	output logic      [`TSA_SYNC_W-1:0] pinOut    // Filtered levels
);
	genvar i;
	generate
		for (i = 0; i < `TSA_SYNC_W; i++) begin : g_bit
			logic s1Reg;
			logic s2Reg;
			logic s3Reg;
			// The output moves only when the last two stages agree.
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					s1Reg <= 1'b1;
					s2Reg <= 1'b1;
					s3Reg <= 1'b1;
					pinOut[i] <= 1'b1;
				end else begin
					s1Reg <= pinIn[i];
					s2Reg <= s1Reg;
					s3Reg <= s2Reg;
					if (s2Reg == s3Reg) begin
						pinOut[i] <= s3Reg;
					end
				end
			end
		end
	endgenerate
endmodule

//--- rtl/tsa_alert.sv
/*
 * Fault queue and alert pin logic of the temperature sensor.
 * Assumes resultValid pulses in the same cycle that each new conversion result first appears stored.
 */
`timescale 1ns/1ps
`include "tsa_consts.svh"

module tsa_alert (
	input  wire logic        ref_clk,      // Block clock
	input  wire logic        nrst,         // Async reset, active low
	input  wire logic        resultValid,  // New result pulse
	input  wire logic [15:0] result,       // Stored temperature word
	input  wire logic [15:0] overLimit,    // Over-temperature limit
	input  wire logic [15:0] hystLimit,    // Hysteresis limit
	input  wire logic [1:0]  faultSel,     // Fault queue depth select
	input  wire logic        intMode,      // Interrupt mode when set
	input  wire logic        polarityHigh, // Active-high alert when set
	input  wire logic        regRead,      // Register read pulse
	output logic             alertActive,  // Alert condition state
	output logic             alertPullLow  // Open-drain enable of alert pin
);
	logic [2:0] faultCntReg;
	logic       belowReg;
	logic       readSeenReg;
	logic [2:0] need;
	logic       fault;
	logic       below;
	logic       tripped;

	assign fault = $signed(result[15:4]) >= $signed(overLimit[15:4]);
	assign below = $signed(result[15:4]) < $signed(hystLimit[15:4]);

	always_comb begin
		case (faultSel)
			2'h0: need = `TSA_FQ_DEPTH0;
			2'h1: need = `TSA_FQ_DEPTH1;
			2'h2: need = `TSA_FQ_DEPTH2;
			default: need = `TSA_FQ_DEPTH3;
		endcase
	end

	assign tripped = resultValid && fault && (({1'b0, faultCntReg} + 4'h1) >= {1'b0, need});

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faultCntReg <= 3'h0;
			belowReg <= 1'b0;
		end else if (resultValid) begin
			belowReg <= below;
			if (!fault) begin
				faultCntReg <= 3'h0;
			end else if (faultCntReg != `TSA_FQ_DEPTH3) begin
				faultCntReg <= faultCntReg + 3'h1;
			end
		end
	end

	// A read only counts once the alert is up; it wins over the clear.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			readSeenReg <= 1'b0;
		end else if (regRead) begin
			readSeenReg <= 1'b1;
		end else if (!alertActive) begin
			readSeenReg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			alertActive <= 1'b0;
		end else if (tripped) begin
			alertActive <= 1'b1;
		end else if (!intMode && resultValid && below) begin
			alertActive <= 1'b0;
		end else if (intMode && readSeenReg && belowReg) begin
			alertActive <= 1'b0;
		end
	end

	assign alertPullLow = alertActive ^ polarityHigh;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	fault_clear_a: assert property (resultValid && !fault |=> faultCntReg == 3'h0)
		else $error("fault count not cleared");
	alert_set_a: assert property (tripped |=> alertActive)
		else $error("alert not raised after fault queue");
	queue_wait_a: assert property (resultValid && fault && !alertActive
		&& faultSel == 2'h3 && faultCntReg == 3'h4 |=> !alertActive)
		else $error("alert raised before sixth fault");
	cmp_clear_a: assert property (resultValid && below && !tripped && !intMode
		|=> !alertActive)
		else $error("comparator alert not cleared");
	int_hold_a: assert property (alertActive && intMode && !readSeenReg && !regRead
		|=> alertActive)
		else $error("interrupt alert cleared without read");
	pin_level_a: assert property ($rose(alertActive) && !polarityHigh
		|-> alertPullLow ##1 (alertPullLow || !alertActive || polarityHigh))
		else $error("active-low alert not pulled low");
endmodule

//--- verif/tsa_bus_master.sv
/*
 Two-wire bus master model: start, stop, byte write and byte read.
 Assumes the data wire is resolved with a pull-up outside this module.
*/
`timescale 1ns/1ps

module tsa_bus_master (
	input  wire logic       ref_clk, // Block clock, paces the bus
	input  wire logic       sdaWire, // Resolved data wire level
	output logic            sclOut,  // Bus clock, idle high
	output logic            sdaOut,  // Data drive, high releases
	output logic            gotByte, // One-cycle read strobe
	output logic [7:0]      rdByte   // Byte just read
);
	initial begin
		sclOut = 1'b1;
		sdaOut = 1'b1;
		gotByte = 1'b0;
		rdByte = 8'h00;
	end

	// A quarter of the 800 ns bus period; all changes land on falling edges.
	task automatic qtr;
		repeat (2) @(negedge ref_clk);
	endtask

	// Data moves late in the low phase because the slave lets go of its
	// acknowledge only about five clocks after it sees the bus clock fall.
	task automatic bitIo(input logic b, output logic s);
		sclOut = 1'b0;
		repeat (5) @(negedge ref_clk);
		sdaOut = b;
		@(negedge ref_clk);
		sclOut = 1'b1;
		@(negedge ref_clk);
		s = sdaWire;
		@(negedge ref_clk);
	endtask

	// Clock is pulled low first so a repeated start never looks like a stop.
	task automatic start;
		sclOut = 1'b0;
		qtr();
		sdaOut = 1'b1;
		qtr();
		sclOut = 1'b1;
		qtr();
		sdaOut = 1'b0;
		qtr();
	endtask

	task automatic stop;
		sclOut = 1'b0;
		qtr();
		sdaOut = 1'b0;
		qtr();
		sclOut = 1'b1;
		qtr();
		sdaOut = 1'b1;
		qtr();
	endtask

	task automatic wbyte(input logic [7:0] d, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitIo(d[i], s);
		bitIo(1'b1, nak);
	endtask

	task automatic rbyte(input logic last);
		logic [7:0] d;
		logic       s;
		for (int i = 7; i >= 0; i--)
			bitIo(1'b1, d[i]);
		bitIo(last, s);
		rdByte = d;
		gotByte = 1'b1;
		@(negedge ref_clk);
		gotByte = 1'b0;
	endtask
endmodule

//--- verif/test_temp_sensor_regs_alert.sv
/*
 Self-checking bench of the sensor register block with a bus master model
 and a converter model.
 Assumes tsa_top and a shortened conversion period.
*/
`timescale 1ns/1ps

module test_temp_sensor_regs_alert;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        adcDone = 1'b0;
	logic [11:0] adcCode = 12'h000;
	logic [11:0] curCode = 12'h000;
	logic        sclPin, mSda, sdaOe, tempAlertOe, adcStart, sensorPowered;
	logic        sdaDrv, alertDrv;
	logic        gotByte;
	logic [7:0]  rdByte;
	logic [7:0]  expQ[$];
	int          fails = 0, cmp_count = 0, cyc = 0, starts = 0, busy = 0;
	// Both pins are open drain with pull-ups: low only while enabled and driving zero.
	wire         sdaWire = mSda & ~(sdaOe & ~sdaDrv);
	wire         alertLow = tempAlertOe & ~alertDrv;

	always #50 ref_clk = ~ref_clk;

	tsa_top #(.CONV_CYCLES(200)) uut (.ref_clk(ref_clk), .nrst(nrst), .sclPin(sclPin),
		.sdaIn(sdaWire), .sdaOut(sdaDrv), .sdaOe(sdaOe), .tempAlertOut(alertDrv),
		.tempAlertOe(tempAlertOe), .adcStart(adcStart), .sensorPowered(sensorPowered),
		.adcDone(adcDone), .adcCode(adcCode));
	tsa_bus_master master (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclPin),
		.sdaOut(mSda), .gotByte(gotByte), .rdByte(rdByte));

	// ----
	// Converter model
	// ----
	// The code is only valid with the done pulse; otherwise it toggles.
	always @(negedge ref_clk) begin
		adcDone <= busy == 1;
		adcCode <= busy == 1 ? curCode : ~adcCode;
		if (adcStart) begin
			starts <= starts + 1;
			busy <= 4;
		end else if (busy > 0)
			busy <= busy - 1;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			end_of_test();
		end
		if (gotByte)
			check(16'(rdByte), 16'(expQ.pop_front()));
	end

	task automatic wb(input logic [7:0] d);
		logic a;
		master.wbyte(d, a);
		check(16'(a), 16'h0);
	endtask

	task automatic wr(input logic [7:0] sel, input logic [15:0] d, input int n);
		master.start();
		wb(8'h90);
		wb(sel);
		if (n == 2)
			wb(d[15:8]);
		if (n > 0)
			wb(d[7:0]);
		master.stop();
	endtask

	// A selector of FF skips the pointer write.
	task automatic rd(input logic [7:0] sel, input logic [15:0] exp, input int n);
		if (sel != 8'hFF)
			wr(sel, 16'h0, 0);
		master.start();
		wb(8'h91);
		for (int i = 0; i < n; i++) begin
			expQ.push_back(exp[15-8*i -: 8]);
			master.rbyte(i == n - 1);
		end
		master.stop();
	endtask

	task automatic conv;
		int s;
		s = starts;
		wait (starts != s);
		repeat (10) @(negedge ref_clk);
	endtask

	task automatic alertIs(input logic e);
		check(16'(alertLow), 16'(e));
	endtask

	initial begin
		logic [15:0] v;
		int          s0;
		int          dep[4];
		void'($urandom(32'h3444));
		dep = '{1, 2, 4, 6};
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(16'(sensorPowered), 16'h1);
		rd(8'hFF, 16'h0000, 2);
		rd(8'h01, 16'h0000, 1);
		rd(8'h02, 16'h4B00, 2);
		rd(8'h03, 16'h5000, 2);
		$display("test done: reset values");
		v = 16'($urandom);
		wr(8'h03, v, 2);
		rd(8'h03, {v[15:4], 4'h0}, 2);
		v = 16'($urandom);
		wr(8'hF2, v, 2);
		rd(8'h02, {v[15:4], 4'h0}, 2);
		wr(8'h00, 16'h1230, 2);
		rd(8'h00, 16'h0000, 2);
		$display("test done: register access");
		wr(8'h03, 16'h1900, 2);
		wr(8'h02, 16'h1800, 2);
		for (int q = 0; q < 4; q++) begin
			curCode = 12'h000;
			conv();
			alertIs(1'b0);
			wr(8'h01, 16'(q << 3), 1);
			conv();
			curCode = 12'h190;
			if (dep[q] > 1) begin
				for (int k = 1; k < dep[q]; k++)
					conv();
				curCode = 12'h18F;
				conv();
				curCode = 12'h190;
			end
			for (int k = 1; k <= dep[q]; k++) begin
				conv();
				check(16'(alertLow), 16'(k == dep[q]));
			end
		end
		rd(8'h00, 16'h1900, 2);
		rd(8'h00, 16'h1900, 1);
		wr(8'h01, 16'h0004, 1);
		check(16'(alertLow), 16'h0);
		$display("test done: fault queue and polarity");
		wr(8'h01, 16'h0000, 1);
		curCode = 12'h000;
		conv();
		wr(8'h01, 16'h0002, 1);
		conv();
		curCode = 12'h190;
		conv();
		check(16'(alertLow), 16'h1);
		curCode = 12'h000;
		conv();
		check(16'(alertLow), 16'h1);
		rd(8'h01, 16'h0200, 1);
		check(16'(alertLow), 16'h0);
		$display("test done: interrupt mode");
		wr(8'h01, 16'h0001, 1);
		s0 = starts;
		repeat (400) @(negedge ref_clk);
		check(16'(sensorPowered), 16'h0);
		check(16'(starts - s0), 16'h0);
		wr(8'h01, 16'h0020, 1);
		check(16'(sensorPowered), 16'h0);
		s0 = starts;
		wr(8'h04, 16'($urandom), 1);
		repeat (400) @(negedge ref_clk);
		check(16'(starts - s0), 16'h1);
		wr(8'h01, 16'h0000, 1);
		check(16'(sensorPowered), 16'h1);
		$display("test done: shutdown and one-shot");
		end_of_test();
	end
endmodule
